// >>> core/uhp_cfg.svh
// Offsets, field positions, reset values and timing of the hub port control
`ifndef UHP_CFG_SVH
`define UHP_CFG_SVH
`define UHP_CLK_MHZ 50
`define UHP_PORT_RST_US 10000
`define UHP_CHIRP_US 1000
`define UHP_SPI_DIV 8
`define UHP_SPI_BITS 80
`define UHP_SPI_CMD 16'h0300
`define UHP_REG_VIDPID 8'h00
`define UHP_REG_DIDCFG 8'h04
`define UHP_REG_DEV 8'h08
`define UHP_REG_PCMD 8'h0C
`define UHP_REG_PSTAT 8'h10
`define UHP_REG_CHANGE 8'h14
`define UHP_REG_STATUS 8'h18
`define UHP_REG_LEDOVR 8'h1C
`define UHP_DEV_ADDR_LSB 0
`define UHP_DEV_CFG_LSB 8
`define UHP_DEV_ALT_BIT 16
`define UHP_OPT_FS_ONLY 0
`define UHP_OPT_STT_ONLY 1
`define UHP_OP_POWER_ON 4'h1
`define UHP_OP_POWER_OFF 4'h2
`define UHP_OP_RESET 4'h3
`define UHP_OP_CLR_ENABLE 4'h4
`define UHP_OP_SUSPEND 4'h5
`define UHP_OP_CLR_SUSPEND 4'h6
`define UHP_RST_ADDR 7'h00
`define UHP_RST_CFG 8'h00
`define UHP_RST_LEDOVR 4'h0
`endif

// >>> core/uhp_hub.sv
// Hub port control: start-up load, attach, chirp, enumeration, ports
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "uhp_cfg.svh"

module uhp_hub import uhp_pkg::*; #(
  parameter int NPORT = 4,
  parameter int PRST_CYC = `UHP_PORT_RST_US * `UHP_CLK_MHZ,
  parameter int CHIRP_CYC = `UHP_CHIRP_US * `UHP_CLK_MHZ,
  parameter int SPI_DIV = `UHP_SPI_DIV
) (
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic spi_cs_n, // EEPROM select, low active
  output logic spi_sclk, // EEPROM clock
  output logic spi_mosi, // EEPROM data in
  input wire logic spi_miso, // EEPROM data out, pin
  input wire logic upstream_vbus_sense, // Upstream VBus, pin
  input wire logic us_bus_reset, // Upstream SE0 reset seen, pin
  input wire logic us_host_chirp, // Host chirp sequence seen, pin
  output logic us_pullup, // Upstream D+ pull-up enable
  output logic us_chirp, // Drive device chirp upstream
  output logic us_hs_mode, // Upstream link at high speed
  output logic us_resume, // Resume signalled upstream
  input wire logic hub_suspended, // Hub itself suspended
  input wire logic pkt_idle, // Between packets on repeater
  input wire logic [NPORT-1:0] ds_connect, // Device attached, pins
  input wire logic [NPORT-1:0] ds_resume_in, // Resume seen on port, pins
  input wire logic [NPORT-1:0] ds_hs_dev, // Attached device is high speed
  input wire logic [NPORT-1:0] ds_babble, // Babble from line monitor
  output logic [NPORT-1:0] ds_se0, // Drive SE0 on port
  output logic [NPORT-1:0] ds_power, // Port power switch enable
  output logic [NPORT-1:0] ds_resume_out, // Drive resume onto port
  output logic [NPORT-1:0] led_green, // Green port indicator
  output logic [NPORT-1:0] route_tt, // Port via translator
  output logic [NPORT-1:0] route_rep, // Port via repeater
  output logic ds_force_fs, // Downstream at 1.1 speeds
  output logic tt_multi, // One translator per port
  output logic tt_bcast // Shared translator broadcasts
);
  localparam int NSYNC = 4 + 2 * NPORT;
  localparam logic [19:0] PRST_END = 20'(PRST_CYC - 1);
  localparam logic [19:0] CHIRP_END = 20'(CHIRP_CYC - 1);
  localparam logic [7:0] SPI_LAST = 8'(`UHP_SPI_BITS - 1);
  localparam logic [7:0] DIV_END = 8'(SPI_DIV / 2 - 1);

  // Three-stage synchronisers; a level counts once stages two and three agree
  logic [NSYNC-1:0] sync1, sync2, sync3, filt;
  always_ff @(posedge clk_sys) begin
    sync1 <= {ds_resume_in, ds_connect, us_host_chirp, us_bus_reset,
              upstream_vbus_sense, spi_miso};
    sync2 <= sync1;
    sync3 <= sync2;
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      filt <= '0;
    end else begin
      for (int i = 0; i < NSYNC; i++) begin
        if (sync2[i] == sync3[i]) begin
          filt[i] <= sync3[i];
        end
      end
    end
  end
  logic miso_f, vbus_f, brst_f, hchirp_f, brst_d;
  logic [NPORT-1:0] conn_f, resm_f, conn_d, resm_d;
  assign miso_f = filt[0];
  assign vbus_f = filt[1];
  assign brst_f = filt[2];
  assign hchirp_f = filt[3];
  assign conn_f = filt[4 +: NPORT];
  assign resm_f = filt[4 + NPORT +: NPORT];
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      brst_d <= 1'b0;
      conn_d <= '0;
      resm_d <= '0;
    end else begin
      brst_d <= brst_f;
      conn_d <= conn_f;
      resm_d <= resm_f;
    end
  end
  logic brst_rise;
  assign brst_rise = brst_f && !brst_d;

  // EEPROM loader: one read command, then the configuration image
  uhp_load_state_type ld_state;
  uhp_eecfg_type eecfg;
  logic [7:0] div_cnt, bit_cnt;
  logic [15:0] tx_sh;
  logic spi_en, loaded;
  assign spi_en = (div_cnt == DIV_END);
  assign loaded = (ld_state == LD_DONE);
  always_ff @(posedge clk_sys) begin
    if (!rstn || loaded || spi_en) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ld_state <= LD_RUN;
      spi_cs_n <= 1'b1;
      spi_sclk <= 1'b0;
      spi_mosi <= 1'b0;
      bit_cnt <= 8'h00;
      tx_sh <= `UHP_SPI_CMD;
      eecfg <= '0;
    end else begin
      case (ld_state)
        LD_RUN: begin
          if (spi_en) begin
            if (spi_cs_n) begin
              spi_cs_n <= 1'b0;
              spi_mosi <= tx_sh[15];
              tx_sh <= {tx_sh[14:0], 1'b0};
            end else if (!spi_sclk) begin
              spi_sclk <= 1'b1;
            end else begin
              // Sampled at the end of the high phase: the pin filter lags
              // miso by four cycles, so SPI_DIV must stay at 6 or more
              eecfg <= {eecfg[$bits(eecfg)-2:0], miso_f};
              spi_sclk <= 1'b0;
              spi_mosi <= tx_sh[15];
              tx_sh <= {tx_sh[14:0], 1'b0};
              bit_cnt <= bit_cnt + 8'h01;
              if (bit_cnt == SPI_LAST) begin
                spi_cs_n <= 1'b1;
                ld_state <= LD_DONE;
              end
            end
          end
        end
        default: begin
          spi_cs_n <= 1'b1;
          spi_sclk <= 1'b0;
        end
      endcase
    end
  end

  // Upstream attach and speed negotiation
  uhp_up_state_type up_state;
  logic [19:0] up_cnt;
  logic chirp_seen;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      up_state <= UP_LOAD;
      up_cnt <= 20'h00000;
      chirp_seen <= 1'b0;
    end else if (loaded && !vbus_f) begin
      up_state <= UP_WAIT_VBUS;
    end else begin
      case (up_state)
        UP_LOAD: if (loaded) up_state <= UP_WAIT_VBUS;
        UP_WAIT_VBUS: up_state <= UP_ATTACHED;
        UP_ATTACHED, UP_FS, UP_HS: begin
          if (brst_rise) begin
            up_cnt <= 20'h00000;
            chirp_seen <= 1'b0;
            up_state <= eecfg.opts[`UHP_OPT_FS_ONLY] ? UP_LISTEN : UP_CHIRP;
          end
        end
        UP_CHIRP: begin
          up_cnt <= up_cnt + 20'h00001;
          if (up_cnt == CHIRP_END || !brst_f) up_state <= UP_LISTEN;
        end
        UP_LISTEN: begin
          if (hchirp_f) chirp_seen <= 1'b1;
          if (!brst_f) up_state <= (chirp_seen || hchirp_f) ? UP_HS : UP_FS;
        end
        default: up_state <= UP_LOAD;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      us_pullup <= 1'b0;
      us_chirp <= 1'b0;
      us_hs_mode <= 1'b0;
    end else begin
      us_pullup <= loaded && vbus_f && (up_state inside {UP_ATTACHED, UP_CHIRP,
                   UP_LISTEN, UP_FS});
      us_chirp <= (up_state == UP_CHIRP) && brst_f && vbus_f;
      us_hs_mode <= (up_state == UP_HS) && vbus_f;
    end
  end

  // Wishbone slave, one wait state, zero for unmapped reads
  logic wb_req, wb_wr;
  uhp_pcmd_type pcmd;
  logic [6:0] dev_addr, next_addr;
  logic [7:0] dev_cfg;
  logic dev_alt, configured, dev_wr;
  logic [3:0] led_ovr;
  logic [NPORT:0] change;
  logic [NPORT:0] change_set;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign dev_wr = wb_wr && (wb_adr_i == `UHP_REG_DEV) && wb_sel_i[0];
  assign next_addr = wb_dat_i[`UHP_DEV_ADDR_LSB +: 7];
  assign pcmd = (wb_wr && wb_adr_i == `UHP_REG_PCMD && wb_sel_i[0]) ?
                uhp_pcmd_type'(wb_dat_i[7:0]) : '0;
  assign configured = (dev_cfg != 8'h00);
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn || brst_rise || !us_pullup && !us_hs_mode) begin
      dev_addr <= `UHP_RST_ADDR;
      dev_cfg <= `UHP_RST_CFG;
      dev_alt <= 1'b0;
    end else if (dev_wr && next_addr != dev_addr) begin
      dev_addr <= next_addr;
      dev_cfg <= `UHP_RST_CFG;
      dev_alt <= 1'b0;
    end else if (wb_wr && wb_adr_i == `UHP_REG_DEV) begin
      if (wb_sel_i[1]) dev_cfg <= wb_dat_i[`UHP_DEV_CFG_LSB +: 8];
      if (wb_sel_i[2]) dev_alt <= wb_dat_i[`UHP_DEV_ALT_BIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      led_ovr <= `UHP_RST_LEDOVR;
    end else if (wb_wr && wb_adr_i == `UHP_REG_LEDOVR && wb_sel_i[0]) begin
      led_ovr <= wb_dat_i[3:0];
    end
  end

  // Per-port state
  logic [NPORT-1:0] p_pwr, p_en, p_arm, p_susp, p_rst;
  logic [19:0] p_cnt [NPORT];
  for (genvar n = 0; n < NPORT; n++) begin : g_port
    logic hit, usable;
    assign hit = (pcmd.port == 2'(n));
    assign usable = eecfg.usable[n];
    always_ff @(posedge clk_sys) begin
      if (!rstn || !configured || !usable) begin
        p_pwr[n] <= 1'b0;
        p_en[n] <= 1'b0;
        p_arm[n] <= 1'b0;
        p_susp[n] <= 1'b0;
        p_rst[n] <= 1'b0;
        p_cnt[n] <= 20'h00000;
        ds_resume_out[n] <= 1'b0;
      end else begin
        ds_resume_out[n] <= 1'b0;
        if (hit && pcmd.op == `UHP_OP_POWER_ON) p_pwr[n] <= 1'b1;
        if (hit && pcmd.op == `UHP_OP_POWER_OFF) begin
          p_pwr[n] <= 1'b0;
          p_en[n] <= 1'b0;
          p_arm[n] <= 1'b0;
        end
        if (hit && pcmd.op == `UHP_OP_RESET && p_pwr[n]) begin
          p_rst[n] <= 1'b1;
          p_en[n] <= 1'b0;
          p_cnt[n] <= 20'h00000;
          p_arm[n] <= 1'b0;
        end else if (p_rst[n]) begin
          p_cnt[n] <= p_cnt[n] + 20'h00001;
          if (p_cnt[n] == PRST_END) begin
            p_rst[n] <= 1'b0;
            p_en[n] <= 1'b1;
            p_arm[n] <= 1'b1;
          end
        end
        if (p_en[n] && p_arm[n] && ds_babble[n]) begin
          p_en[n] <= 1'b0;
          p_arm[n] <= 1'b0;
        end
        if (hit && pcmd.op == `UHP_OP_CLR_ENABLE) begin
          p_en[n] <= 1'b0;
          p_arm[n] <= 1'b0;
        end
        if (!conn_f[n]) begin
          p_en[n] <= 1'b0;
          p_susp[n] <= 1'b0;
        end
        if (hit && pcmd.op == `UHP_OP_SUSPEND && p_en[n]) p_susp[n] <= 1'b1;
        if (hit && pcmd.op == `UHP_OP_CLR_SUSPEND && p_susp[n]) begin
          p_susp[n] <= 1'b0;
          ds_resume_out[n] <= 1'b1;
        end
        if (p_susp[n] && resm_f[n] && !resm_d[n] && !hub_suspended) begin
          p_susp[n] <= 1'b0;
        end
      end
    end
    assign change_set[n+1] = p_pwr[n] && (conn_f[n] != conn_d[n]) ||
      p_en[n] && p_arm[n] && ds_babble[n] ||
      p_rst[n] && p_cnt[n] == PRST_END ||
      p_susp[n] && resm_f[n] && !resm_d[n] && !hub_suspended;
  end
  assign change_set[0] = 1'b0;

  // Endpoint 1 change bitmap; a new event wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      change <= '0;
    end else begin
      for (int i = 0; i <= NPORT; i++) begin
        if (change_set[i]) begin
          change[i] <= 1'b1;
        end else if (wb_wr && wb_adr_i == `UHP_REG_CHANGE && wb_sel_i[0] &&
                     wb_dat_i[i]) begin
          change[i] <= 1'b0;
        end
      end
    end
  end

  // Resume upstream only from a suspended port while the hub sleeps
  always_ff @(posedge clk_sys) begin
    if (!rstn || !hub_suspended) begin
      us_resume <= 1'b0;
    end else if ((p_susp & resm_f & ~resm_d) != '0) begin
      us_resume <= 1'b1;
    end
  end

  // Port drive, indicators and routing
  logic multi_ok;
  assign multi_ok = us_hs_mode && configured && dev_alt &&
                    !eecfg.opts[`UHP_OPT_STT_ONLY];
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ds_se0 <= '1;
      ds_power <= '0;
      led_green <= '0;
      tt_multi <= 1'b0;
      tt_bcast <= 1'b0;
    end else begin
      ds_se0 <= configured ? p_rst : '1;
      ds_power <= configured ? p_pwr : '0;
      led_green <= p_en & ~led_ovr[NPORT-1:0];
      tt_multi <= multi_ok;
      tt_bcast <= us_hs_mode && configured && !multi_ok;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      route_tt <= '0;
      route_rep <= '0;
      ds_force_fs <= 1'b1;
    end else if (pkt_idle) begin
      // Late switch is safer than tearing a packet in half
      route_tt <= us_hs_mode ? p_en & ~ds_hs_dev : '0;
      route_rep <= us_hs_mode ? p_en & ds_hs_dev : p_en;
      ds_force_fs <= !us_hs_mode;
    end
  end

  // Read data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      if (wb_adr_i == `UHP_REG_VIDPID) begin
        wb_dat_o <= {eecfg.vid, eecfg.pid};
      end else if (wb_adr_i == `UHP_REG_DIDCFG) begin
        wb_dat_o <= {eecfg.did, eecfg.removable, eecfg.usable, eecfg.opts};
      end else if (wb_adr_i == `UHP_REG_DEV) begin
        wb_dat_o <= {15'h0000, dev_alt, dev_cfg, 1'b0, dev_addr};
      end else if (wb_adr_i == `UHP_REG_PSTAT) begin
        wb_dat_o <= {12'h000, p_rst, p_susp, p_en, p_pwr, conn_f};
      end else if (wb_adr_i == `UHP_REG_CHANGE) begin
        wb_dat_o <= {27'h0000000, change};
      end else if (wb_adr_i == `UHP_REG_STATUS) begin
        wb_dat_o <= {26'h0000000, us_resume, tt_multi, configured,
                     us_hs_mode, us_pullup, loaded};
      end else if (wb_adr_i == `UHP_REG_LEDOVR) begin
        wb_dat_o <= {28'h0000000, led_ovr};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  logic [NPORT-1:0] babble_hit;
  assign babble_hit = p_en & p_arm & ds_babble;

  sequence s_rst_cmd;
    pcmd.port == 2'd0 && pcmd.op == `UHP_OP_RESET && p_pwr[0] && configured;
  endsequence
  sequence s_rst_drive;
    ds_se0[0] && !p_en[0];
  endsequence

  a_pullup_after_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    us_pullup |-> loaded && $past(vbus_f)) else $error("pullup early");
  a_chirp_in_reset: assert property (@(posedge clk_sys) disable iff (!rstn)
    us_chirp |-> $past(brst_f) && us_pullup) else $error("chirp off");
  a_hs_drops_pullup: assert property (@(posedge clk_sys) disable iff (!rstn)
    us_hs_mode |-> !us_pullup) else $error("pullup in hs");
  a_fs_no_tt: assert property (@(posedge clk_sys) disable iff (!rstn)
    !us_hs_mode && $past(!us_hs_mode) && $past(pkt_idle) |-> route_tt == '0)
    else $error("tt used at fs");
  a_bus_reset_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    brst_rise |=> dev_cfg == 8'h00 && dev_addr == 7'h00)
    else $error("not cleared");
  a_new_addr_unconf: assert property (@(posedge clk_sys) disable iff (!rstn)
    dev_wr && next_addr != dev_addr && !brst_rise |=> dev_cfg == 8'h00)
    else $error("stays configured");
  a_multi_needs_alt: assert property (@(posedge clk_sys) disable iff (!rstn)
    tt_multi |-> $past(dev_alt && us_hs_mode) && !tt_bcast)
    else $error("multi wrong");
  a_unconf_ports: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(!configured) |-> ds_se0 == '1 && ds_power == '0)
    else $error("port driven");
  a_route_boundary: assert property (@(posedge clk_sys) disable iff (!rstn)
    !$stable(route_rep) |-> $past(pkt_idle)) else $error("mid packet");
  a_babble_disable: assert property (@(posedge clk_sys) disable iff (!rstn)
    babble_hit != '0 |=> (p_en & $past(babble_hit)) == '0)
    else $error("babble kept");
  a_port_reset: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_rst_cmd |=> ##1 s_rst_drive) else $error("reset not driven");
  a_change_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    change_set[1] |=> change[1]) else $error("change lost");
endmodule : uhp_hub
`default_nettype wire

// >>> core/uhp_pkg.sv
// Types shared by the hub port control logic
package uhp_pkg;
  typedef enum logic [2:0] {
    UP_LOAD, UP_WAIT_VBUS, UP_ATTACHED, UP_CHIRP, UP_LISTEN, UP_FS, UP_HS
  } uhp_up_state_type;
  typedef enum logic [1:0] {LD_RUN, LD_DONE} uhp_load_state_type;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] rsv;
    logic [1:0] port;
  } uhp_pcmd_type;
  typedef struct packed {
    logic [15:0] vid;
    logic [15:0] pid;
    logic [15:0] did;
    logic [3:0] removable;
    logic [3:0] usable;
    logic [7:0] opts;
  } uhp_eecfg_type;
endpackage : uhp_pkg

// >>> verification/uhp_eeprom_model.sv
// Behavioural SPI configuration memory answering the hub's start-up load
`timescale 1ns/1ns
`default_nettype none

module uhp_eeprom_model #(
  parameter logic [63:0] IMAGE = 64'h0
) (
  input wire logic cs_n, // Select, low active
  input wire logic sclk, // Mode-0 clock from the hub
  input wire logic mosi, // Command and address from the hub
  output logic miso, // Data to the hub
  output logic [15:0] cmd_seen // First 16 bits shifted in
);
  int nbit = 0;
  initial miso = 1'b0;
  initial cmd_seen = 16'h0;
  always @(negedge cs_n) begin
    nbit = 0;
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (nbit < 16) begin
        cmd_seen = {cmd_seen[14:0], mosi};
      end
      nbit = nbit + 1;
    end
  end
  // Data moves on the fall so it is settled at the next rise
  always @(negedge sclk or posedge cs_n) begin
    if (!cs_n && nbit >= 16 && nbit < 80) begin
      miso = IMAGE[79 - nbit];
    end else begin
      miso = ~miso; // Undriven line must not look stable
    end
  end
endmodule : uhp_eeprom_model
`default_nettype wire

// >>> verification/uhp_hub_bench.sv
// Self-checking bench for the hub port control block
`timescale 1ns/1ns
`default_nettype none
`include "uhp_cfg.svh"

module uhp_hub_bench import uhp_pkg::*; ;
  logic clk_sys, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic vbus = 1'b0, busrst = 1'b0, hchirp = 1'b0, hsusp = 1'b0, pidle = 1'b1;
  logic [7:0] adr = 8'h0, r;
  logic [3:0] sel = 4'h0, conn = 4'h0, resi = 4'h0, hsd = 4'h0, bab = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, cs_n, sclk, mosi, miso, pu, chirp, hs, usres, ffs, ttm, ttb;
  logic [3:0] se0, pwr, reso, led, rtt, rrep;
  logic [15:0] cmd_seen;
  logic [1:0] acc;
  logic [3:0] rseen = 4'h0;
  int mismatches = 0, comparisons = 0, p, n;
  // Identity fields are arbitrary
  localparam logic [63:0] IMG = {48'h1234_5678_9ABC, 16'h3F00};

  uhp_hub #(.PRST_CYC(20), .CHIRP_CYC(20)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso(miso), .upstream_vbus_sense(vbus),
    .us_bus_reset(busrst), .us_host_chirp(hchirp), .us_pullup(pu),
    .us_chirp(chirp), .us_hs_mode(hs), .us_resume(usres),
    .hub_suspended(hsusp), .pkt_idle(pidle), .ds_connect(conn),
    .ds_resume_in(resi), .ds_hs_dev(hsd), .ds_babble(bab), .ds_se0(se0),
    .ds_power(pwr), .ds_resume_out(reso), .led_green(led), .route_tt(rtt),
    .route_rep(rrep), .ds_force_fs(ffs), .tt_multi(ttm), .tt_bcast(ttb));
  uhp_eeprom_model #(.IMAGE(IMG)) ee_u (.cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .miso(miso), .cmd_seen(cmd_seen));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Catches one-cycle resume pulses driven onto the ports
  always @(posedge clk_sys) begin
    if (rstn) begin
      rseen <= rseen | reso;
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick

  // Entered and left just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
    if (k >= 50) begin
      mismatches++;
      end_sim();
    end
  endtask : wb

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int k;
    k = 0;
    do begin
      wb(1'b0, a, 32'h0, 4'hF);
      k++;
    end while ((q & m) !== m && k < 400);
    chk(q & m, m);
  endtask : poll

  task automatic pc(input logic [3:0] op, input logic [1:0] pt);
    wb(1'b1, `UHP_REG_PCMD, {24'h0, op, 2'b00, pt}, 4'h1);
  endtask : pc

  task automatic wchirp();
    n = 0;
    while (chirp !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(32'(chirp), 32'h1);
  endtask : wchirp

  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end

  initial begin
    tick(8);
    rstn <= 1'b1;
    tick(5);
    chk(32'({pu, se0, pwr}), 32'h0F0);
    poll(`UHP_REG_STATUS, 32'h1);
    chk(32'(cmd_seen), 32'(`UHP_SPI_CMD));
    wb(1'b0, `UHP_REG_VIDPID, 32'h0, 4'hF);
    chk(q, IMG[63:32]);
    wb(1'b0, `UHP_REG_DIDCFG, 32'h0, 4'hF);
    chk(q, IMG[31:0]);
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    chk(q, 32'h0);
    vbus <= 1'b1;
    poll(`UHP_REG_STATUS, 32'h2);
    // Old host: reset with no answering chirp
    busrst <= 1'b1;
    wchirp();
    tick(40);
    busrst <= 1'b0;
    tick(10);
    chk(32'({hs, ffs, pu}), 32'h3);
    vbus <= 1'b0;
    tick(10);
    chk(32'(pu), 32'h0);
    vbus <= 1'b1;
    poll(`UHP_REG_STATUS, 32'h2);
    busrst <= 1'b1;
    wchirp();
    // Host answers only once the device chirp is over
    tick(30);
    chk(32'(chirp), 32'h0);
    hchirp <= 1'b1;
    tick(10);
    busrst <= 1'b0;
    hchirp <= 1'b0;
    tick(10);
    chk(32'({hs, ffs, pu}), 32'h4);
    wb(1'b1, `UHP_REG_DEV, 32'h5, 4'h1);
    wb(1'b1, `UHP_REG_DEV, 32'h100, 4'h2);
    wb(1'b1, `UHP_REG_DEV, 32'h6, 4'h1);
    wb(1'b1, `UHP_REG_DEV, 32'h100, 4'h0);
    wb(1'b0, `UHP_REG_DEV, 32'h0, 4'hF);
    chk(q, 32'h6);
    wb(1'b1, `UHP_REG_DEV, 32'h100, 4'h2);
    tick(3);
    chk(32'({ttm, ttb, se0, pwr}), 32'h100);
    wb(1'b1, `UHP_REG_DEV, 32'h10000, 4'h4);
    tick(1);
    chk(32'({ttm, ttb}), 32'h2);
    for (p = 0; p < 4; p++) begin
      pc(`UHP_OP_POWER_ON, p[1:0]);
    end
    r = lfsr(8'h23);
    hsd <= r[3:0];
    conn <= 4'hF;
    for (p = 0; p < 4; p++) begin
      pc(`UHP_OP_RESET, p[1:0]);
    end
    tick(30);
    chk(32'({pwr, rrep, rtt}), 32'({4'hF, r[3:0], ~r[3:0]}));
    pidle <= 1'b0;
    hsd <= ~r[3:0];
    tick(5);
    chk(32'({rrep, rtt}), 32'({r[3:0], ~r[3:0]}));
    pidle <= 1'b1;
    wb(1'b0, `UHP_REG_CHANGE, 32'h0, 4'hF);
    chk(q, 32'h1E);
    r = lfsr(r);
    p = int'(r[1:0]);
    pc(`UHP_OP_RESET, r[1:0]);
    tick(1);
    chk(32'(se0[p]), 32'h1);
    poll(`UHP_REG_PSTAT, 32'h100 << p);
    chk(32'(led[p]), 32'h1);
    bab[p] <= 1'b1;
    tick(3);
    bab <= 4'h0;
    wb(1'b0, `UHP_REG_PSTAT, 32'h0, 4'hF);
    chk(q & (32'h100 << p), 32'h0);
    pc(`UHP_OP_RESET, r[1:0]);
    poll(`UHP_REG_PSTAT, 32'h100 << p);
    pc(`UHP_OP_CLR_ENABLE, r[1:0]);
    wb(1'b0, `UHP_REG_PSTAT, 32'h0, 4'hF);
    chk(q & (32'h100 << p), 32'h0);
    pc(`UHP_OP_RESET, r[1:0]);
    poll(`UHP_REG_PSTAT, 32'h100 << p);
    pc(`UHP_OP_SUSPEND, r[1:0]);
    wb(1'b1, `UHP_REG_CHANGE, 32'h1E, 4'h1);
    resi[p] <= 1'b1;
    tick(8);
    resi <= 4'h0;
    tick(8);
    wb(1'b0, `UHP_REG_CHANGE, 32'h0, 4'hF);
    chk(q & 32'h1E, 32'h2 << p);
    chk(32'({usres, reso}), 32'h0);
    pc(`UHP_OP_SUSPEND, r[1:0]);
    hsusp <= 1'b1;
    resi[p] <= 1'b1;
    acc = 2'b00;
    repeat (20) begin
      tick(1);
      acc = acc | {usres, |reso};
    end
    chk(32'(acc), 32'h2);
    chk(32'(rseen), 32'h0);
    resi <= 4'h0;
    hsusp <= 1'b0;
    pc(`UHP_OP_CLR_SUSPEND, r[1:0]);
    chk(32'(rseen), 32'h1 << p);
    wb(1'b1, `UHP_REG_LEDOVR, 32'h1 << p, 4'h1);
    chk(32'(led), 32'hF ^ (32'h1 << p));
    pc(`UHP_OP_POWER_OFF, r[1:0]);
    chk(32'(pwr), 32'hF ^ (32'h1 << p));
    busrst <= 1'b1;
    tick(5);
    wb(1'b0, `UHP_REG_DEV, 32'h0, 4'hF);
    chk(q, 32'h0);
    chk(32'({se0, pwr}), 32'hF0);
    busrst <= 1'b0;
    end_sim();
  end
endmodule : uhp_hub_bench
`default_nettype wire
